/* File: design/utr_regs.sv */
// module: read-only upstream time-of-flight result register bank
`timescale 1ns/1ps
module utr_regs #(
  parameter int RATIO_W = utr_pkg::RATIO_W,
  parameter int INT_W   = utr_pkg::INT_W,
  parameter int FRAC_W  = utr_pkg::FRAC_W,
  parameter int REG_W   = utr_pkg::REG_W
) (
  input  wire logic                 CLOCK,
  input  wire logic                 RST,
  input  wire utr_pkg::utr_result_t RESULT,
  input  wire logic                 RESULT_VALID,
  input  wire utr_pkg::utr_access_t ACCESS,
  output logic [15:0]               RDATA,
  output logic                      RVALID,
  output logic                      WR_IGNORED
);

  // ==========================================================================
  // elaboration checks
  // ==========================================================================
  // the port structs fix every field width, so only the packaged widths fit
  if (RATIO_W != utr_pkg::RATIO_W || INT_W != utr_pkg::INT_W ||
      FRAC_W != utr_pkg::FRAC_W || REG_W != utr_pkg::REG_W) begin : g_bad_width
    $error("utr_regs: widths differ from the result struct");
  end
  if (2 * RATIO_W != REG_W || INT_W >= REG_W || FRAC_W > REG_W) begin : g_bad_pack
    $error("utr_regs: fields do not pack into one register word");
  end

  // ==========================================================================
  // packing of one measurement into register words
  // ==========================================================================
  // ratio bytes pass through unchanged: msb weight 1, lsb 1/128
  wire logic [REG_W-1:0] word_ratio = {RESULT.ratio_t1_t2, RESULT.ratio_t1_ideal};
  // top bit of integer words is unused and reads zero
  wire logic [REG_W-1:0] word_h1i   = REG_W'(RESULT.hit1_int);
  wire logic [REG_W-1:0] word_h1f   = REG_W'(RESULT.hit1_frac);
  wire logic [REG_W-1:0] word_h2i   = REG_W'(RESULT.hit2_int);
  wire logic [utr_pkg::NUM_REGS*REG_W-1:0] load_data = {word_h2i, word_h1f, word_h1i, word_ratio};

  // ==========================================================================
  // address decode
  // ==========================================================================
  wire logic       hit_c4  = (ACCESS.addr == utr_pkg::ADDR_WAVE_RATIO);
  wire logic       hit_c5  = (ACCESS.addr == utr_pkg::ADDR_HIT1_INT);
  wire logic       hit_c6  = (ACCESS.addr == utr_pkg::ADDR_HIT1_FRAC);
  wire logic       hit_c7  = (ACCESS.addr == utr_pkg::ADDR_HIT2_INT);
  wire logic       mapped  = hit_c4 | hit_c5 | hit_c6 | hit_c7;
  wire logic [1:0] rd_idx  = {hit_c6 | hit_c7, hit_c5 | hit_c7};
  wire logic       rd_req  = ACCESS.rd & ~ACCESS.wr;

  logic [15:0] store_q;
  logic        rd_pend_ff;
  logic        rd_map_ff;
  logic [15:0] rdata_ff;
  logic        rvalid_ff;
  logic        wr_ign_ff;

  // one shared edge loads all four words, so no torn reads are possible
  utr_store #(
    .DEPTH (utr_pkg::NUM_REGS),
    .AW    (utr_pkg::IDX_W),
    .W     (utr_pkg::REG_W)
  ) u_store (
    .clk        (CLOCK),
    .rst        (RST),
    .load       (RESULT_VALID),
    .load_data  (load_data),
    .rd_idx     (rd_idx),
    .rd_data_ff (store_q)
  );

  // ==========================================================================
  // read path: store output is registered, so answer comes two edges later
  // ==========================================================================
  wire logic        nxt_rd_map = rd_req & mapped;
  wire logic [15:0] nxt_answer = rd_map_ff ? store_q : utr_pkg::UNMAPPED_RD;
  // between answers the last word stays on the output
  wire logic [15:0] nxt_rdata  = rd_pend_ff ? nxt_answer : rdata_ff;

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      rd_pend_ff <= 1'b0;
      rd_map_ff  <= 1'b0;
      rvalid_ff  <= 1'b0;
    end else begin
      rd_pend_ff <= rd_req;
      rd_map_ff  <= nxt_rd_map;
      rvalid_ff  <= rd_pend_ff;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      rdata_ff <= utr_pkg::REG_RESET;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // writes never reach the store; flagged for the port logic only
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      wr_ign_ff <= 1'b0;
    end else begin
      wr_ign_ff <= ACCESS.wr;
    end
  end

  assign RDATA      = rdata_ff;
  assign RVALID     = rvalid_ff;
  assign WR_IGNORED = wr_ign_ff;

  // ==========================================================================
  // checks
  // ==========================================================================
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  chk_write_no_effect: assert property (
    (ACCESS.wr && !RESULT_VALID) |=> (u_store.mem_ff[0] == $past(u_store.mem_ff[0]))
                                   && (u_store.mem_ff[1] == $past(u_store.mem_ff[1]))
                                   && (u_store.mem_ff[2] == $past(u_store.mem_ff[2]))
                                   && (u_store.mem_ff[3] == $past(u_store.mem_ff[3])))
    else $error("write altered a result register");

  chk_reset_clear: assert property (
    @(posedge CLOCK) disable iff (1'b0) RST |=> (RDATA == 16'h0000 && !RVALID))
    else $error("outputs not clear after reset");

  chk_store_clear: assert property (
    @(posedge CLOCK) disable iff (1'b0) RST |=> (u_store.mem_ff[0] == utr_pkg::REG_RESET
                                              && u_store.mem_ff[1] == utr_pkg::REG_RESET
                                              && u_store.mem_ff[2] == utr_pkg::REG_RESET
                                              && u_store.mem_ff[3] == utr_pkg::REG_RESET))
    else $error("result register not clear after reset");

  chk_hold_between_loads: assert property (
    !RESULT_VALID |=> ($stable(u_store.mem_ff[0]) && $stable(u_store.mem_ff[1])
                    && $stable(u_store.mem_ff[2]) && $stable(u_store.mem_ff[3])))
    else $error("result register changed without a load");

  chk_ratio_upper: assert property (
    RESULT_VALID |=> (u_store.mem_ff[0][15:8] == $past(RESULT.ratio_t1_t2)))
    else $error("t1/t2 ratio not in upper byte");

  chk_ratio_lower: assert property (
    RESULT_VALID |=> (u_store.mem_ff[0][7:0] == $past(RESULT.ratio_t1_ideal)))
    else $error("ideal ratio not in lower byte");

  chk_hit1_int: assert property (
    RESULT_VALID |=> (u_store.mem_ff[1] == {1'b0, $past(RESULT.hit1_int)}))
    else $error("hit1 integer wrong");

  chk_hit1_frac: assert property (
    RESULT_VALID |=> (u_store.mem_ff[2] == $past(RESULT.hit1_frac)))
    else $error("hit1 fraction wrong");

  chk_hit2_int: assert property (
    RESULT_VALID |=> (u_store.mem_ff[3] == {1'b0, $past(RESULT.hit2_int)}))
    else $error("hit2 integer wrong");

  chk_int_ceiling: assert property (
    (u_store.mem_ff[1] <= REG_W'(utr_pkg::INT_CEILING))
      && (u_store.mem_ff[3] <= REG_W'(utr_pkg::INT_CEILING)))
    else $error("integer word above its ceiling");

  chk_read_latency: assert property (
    (rd_req && hit_c6 && !RESULT_VALID) ##1 !RESULT_VALID
      |=> (RVALID && RDATA == $past(u_store.mem_ff[2], 2)))
    else $error("read data or latency wrong");

  chk_read_ratio: assert property (
    (rd_req && hit_c4) |-> ##2 (RVALID && RDATA == $past(u_store.mem_ff[0], 2)))
    else $error("wave ratio read wrong");

  chk_read_hit1i: assert property (
    (rd_req && hit_c5) |-> ##2 (RVALID && RDATA == $past(u_store.mem_ff[1], 2)))
    else $error("hit1 integer read wrong");

  chk_read_hit2i: assert property (
    (rd_req && hit_c7) |-> ##2 (RVALID && RDATA == $past(u_store.mem_ff[3], 2)))
    else $error("hit2 integer read wrong");

  chk_unmapped_zero: assert property (
    (rd_req && !mapped) |-> ##2 (RVALID && RDATA == 16'h0000))
    else $error("unmapped read not zero");

  chk_rdwr_not_read: assert property (
    (ACCESS.rd && ACCESS.wr) |-> ##2 !RVALID)
    else $error("read with write high was answered");

  chk_valid_source: assert property (
    RVALID |-> $past(rd_req, 2))
    else $error("answer without a read");

  chk_rdata_hold: assert property (
    (!RVALID && !$past(RST)) |-> $stable(RDATA))
    else $error("read data moved between answers");

  chk_wr_flag_set: assert property (
    ACCESS.wr |=> WR_IGNORED)
    else $error("write not flagged");

  chk_wr_flag_clear: assert property (
    !ACCESS.wr |=> !WR_IGNORED)
    else $error("write flag without a write");

  // ==========================================================================
  // covers
  // ==========================================================================
  cov_load: cover property (RESULT_VALID);
  cov_read_mapped: cover property (rd_req && mapped ##2 RVALID);
  cov_write_ignored: cover property (ACCESS.wr ##1 WR_IGNORED);
  cov_read_after_load: cover property (RESULT_VALID ##1 (rd_req && hit_c7));
  cov_read_unmapped: cover property (rd_req && !mapped ##2 RVALID);

endmodule

/* File: design/utr_pkg.sv */
// package: register map, field layout and carrier types of the upstream tof result bank
package utr_pkg;

  // ==========================================================================
  // register map
  // ==========================================================================
  localparam logic [7:0] ADDR_WAVE_RATIO = 8'hC4;
  localparam logic [7:0] ADDR_HIT1_INT   = 8'hC5;
  localparam logic [7:0] ADDR_HIT1_FRAC  = 8'hC6;
  localparam logic [7:0] ADDR_HIT2_INT   = 8'hC7;
  localparam int         NUM_REGS        = 4;
  localparam int         IDX_W           = 2;

  // ==========================================================================
  // field layout
  // ==========================================================================
  localparam int          RATIO_W      = 8;
  localparam int          INT_W        = 15;
  localparam int          FRAC_W       = 16;
  localparam int          REG_W        = 16;
  localparam logic [15:0] REG_RESET    = 16'h0000;
  localparam logic [14:0] INT_CEILING  = 15'h7FFF;
  localparam logic [15:0] FRAC_CEILING = 16'hFFFF;
  localparam logic [15:0] UNMAPPED_RD  = 16'h0000;

  // one completed upstream measurement, as delivered by the engine
  typedef struct packed {
    logic [7:0]  ratio_t1_t2;
    logic [7:0]  ratio_t1_ideal;
    logic [14:0] hit1_int;
    logic [15:0] hit1_frac;
    logic [14:0] hit2_int;
  } utr_result_t;

  // host access on the serial port's internal register side
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [15:0] wdata;
  } utr_access_t;

endpackage

/* File: design/utr_store.sv */
// module: small register-output store for the four result words
`timescale 1ns/1ps
module utr_store #(
  parameter int DEPTH = 4,
  parameter int AW    = 2,
  parameter int W     = 16
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 load,
  input  wire logic [DEPTH*W-1:0]   load_data,
  input  wire logic [AW-1:0]        rd_idx,
  output logic      [W-1:0]         rd_data_ff
);

  if (DEPTH < 1 || DEPTH > (1 << AW)) begin : g_bad_depth
    $error("utr_store: index too narrow for the depth");
  end

  logic [W-1:0] mem_ff [DEPTH];

  // ==========================================================================
  // storage, all words replaced in one edge
  // ==========================================================================
  for (genvar i = 0; i < DEPTH; i++) begin : g_word
    always_ff @(posedge clk) begin
      if (rst) begin
        mem_ff[i] <= W'(utr_pkg::REG_RESET);
      end else if (load) begin
        mem_ff[i] <= load_data[i*W +: W];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_data_ff <= W'(utr_pkg::REG_RESET);
    end else begin
      rd_data_ff <= mem_ff[rd_idx];
    end
  end

endmodule

/* File: sim/utr_host.sv */
// host model: issues register reads and writes on the access port
`timescale 1ns/1ps
module utr_host (
  input  wire logic            clk,
  output utr_pkg::utr_access_t acc
);
  initial acc = '0;
  // request changes at the falling edge and stands one whole cycle
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [15:0] wdata);
    @(negedge clk);
    acc = '{rd: !wr, wr: wr, addr: addr, wdata: wdata};
    @(negedge clk);
    acc = '0;
  endtask
  // read and write high together: the bank must treat it as a write
  task automatic xfer_both(input logic [7:0] addr);
    @(negedge clk);
    acc = '{rd: 1'b1, wr: 1'b1, addr: addr, wdata: 16'h0000};
    @(negedge clk);
    acc = '0;
  endtask
endmodule

/* File: sim/upstream_tof_result_regs_test.sv */
// testbench: random and corner reads of the upstream tof result bank
`timescale 1ns/1ps
`define CHK(nm, e, a) begin num_checks++; if ((a) !== (e)) begin mismatches++; $display("wrong value %s expected %h seen %h", nm, e, a); end end
module upstream_tof_result_regs_test;
  logic                 clock;
  logic                 rst;
  utr_pkg::utr_result_t result;
  logic                 result_valid;
  utr_pkg::utr_access_t access;
  logic [15:0]          rdata;
  logic                 rvalid;
  logic                 wr_ignored;
  utr_pkg::utr_result_t model;
  logic [31:0]          lfsr;
  logic [31:0]          hi;
  int                   mismatches;
  int                   num_checks;

  utr_regs DUT (.CLOCK(clock), .RST(rst), .RESULT(result), .RESULT_VALID(result_valid), .ACCESS(access),
                .RDATA(rdata), .RVALID(rvalid), .WR_IGNORED(wr_ignored));
  utr_host host (.clk(clock), .acc(access));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // ==========================================================================
  // expectations
  // ==========================================================================
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [15:0] expect_word(input utr_pkg::utr_result_t r, input logic [7:0] a);
    case (a)
      utr_pkg::ADDR_WAVE_RATIO: return {r.ratio_t1_t2, r.ratio_t1_ideal};
      utr_pkg::ADDR_HIT1_INT:   return {1'b0, r.hit1_int};
      utr_pkg::ADDR_HIT1_FRAC:  return r.hit1_frac;
      utr_pkg::ADDR_HIT2_INT:   return {1'b0, r.hit2_int};
      default:                  return 16'h0000;
    endcase
  endfunction

  // ==========================================================================
  // bus tasks
  // ==========================================================================
  task automatic read_chk(input logic [7:0] a);
    host.xfer(1'b0, a, lfsr[15:0]);
    @(negedge clock);
    `CHK("rvalid", 1'b1, rvalid)
    `CHK("rdata", expect_word(model, a), rdata)
    `CHK("wr_ignored low", 1'b0, wr_ignored)
    @(negedge clock);
    `CHK("rvalid low", 1'b0, rvalid)
  endtask

  // all four words hand over at one edge, so reads after it see one measurement
  task automatic load(input utr_pkg::utr_result_t r);
    @(negedge clock);
    result = r;
    result_valid = 1'b1;
    @(negedge clock);
    result_valid = 1'b0;
    model = r;
  endtask

  task automatic read_all();
    for (int i = 0; i < 5; i++) read_chk(8'(8'hC4 + i));
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ==========================================================================
  // sequence
  // ==========================================================================
  initial begin
    repeat (5000) @(posedge clock);
    mismatches++;
    conclude();
  end

  initial begin
    lfsr = 32'h4163;
    hi = 32'h0;
    rst = 1'b1;
    result = '0;
    result_valid = 1'b0;
    mismatches = 0;
    num_checks = 0;
    model = '0;
    repeat (20) @(negedge clock);
    rst = 1'b0;
    read_all();
    load('1);
    read_all();
    for (int n = 0; n < 20; n++) begin
      lfsr = next_rand(lfsr);
      hi = lfsr;
      lfsr = next_rand(lfsr);
      load({hi, lfsr[30:0]});
      host.xfer(1'b1, 8'(8'hC4 + lfsr[1:0]), lfsr[31:16]);
      `CHK("wr_ignored", 1'b1, wr_ignored)
      read_all();
    end
    // read and write together is a refused write, never a read
    host.xfer_both(8'hC6);
    `CHK("wr_ignored both", 1'b1, wr_ignored)
    @(negedge clock);
    `CHK("rvalid both", 1'b0, rvalid)
    read_all();
    // a second reset in mid-run must wipe the last measurement
    rst = 1'b1;
    model = '0;
    @(negedge clock);
    rst = 1'b0;
    read_all();
    conclude();
  end
endmodule
